// [logic/smtw_pkg.sv]
// constants shared by the turnaround, external wait and byte lane logic
package smtw_pkg;
   localparam int          BANKS       = 8;
   localparam int          BANK_W      = 3;
   localparam int          TURN_W      = 4;
   localparam int          WS_W        = 5;
   localparam int          BEATS_W     = 2;
   localparam logic [1:0]  SIZE_BYTE   = 2'h0;
   localparam logic [1:0]  SIZE_HALF   = 2'h1;
   localparam logic [1:0]  SIZE_WORD   = 2'h2;
   localparam logic [1:0]  BEATS8_WORD = 2'h3;
   localparam logic [1:0]  BEATS8_HALF = 2'h1;
   localparam logic [1:0]  BEATS16_WORD = 2'h1;
   localparam logic [1:0]  BEATS_ONE   = 2'h0;
   localparam logic [1:0]  BEAT_ONE    = 2'h1;
   localparam logic [1:0]  ADDR_WORD8  = 2'h3;
   localparam logic [1:0]  ADDR_WORD16 = 2'h2;
   localparam logic [1:0]  ADDR_STEP8  = 2'h1;
   localparam logic [1:0]  ADDR_STEP16 = 2'h2;
   localparam logic [1:0]  ADDR_RST    = 2'h0;
   localparam logic [1:0]  LANES_BOTH  = 2'h0;
   localparam logic [1:0]  LANES_NONE  = 2'h3;
   localparam logic [1:0]  LANES_LOW   = 2'h2;
   localparam logic [1:0]  LANES_HIGH  = 2'h1;
   localparam logic [7:0]  CS_NONE     = 8'hff;
   localparam logic [7:0]  CS_ONE      = 8'h01;
   localparam logic [4:0]  CNT_ZERO    = 5'h00;
   localparam logic [4:0]  CNT_ONE     = 5'h01;
   localparam logic [31:0] DATA_RST    = 32'h0000_0000;
   localparam logic [15:0] EXT_RST     = 16'h0000;
   localparam logic [7:0]  FLAGS_RST   = 8'h00;
   localparam logic [2:0]  BANK_RST    = 3'h0;
   localparam logic        POL_HIGH    = 1'b1;
   typedef enum logic [2:0] {ST_IDLE, ST_TURN, ST_ACCESS, ST_WAIT_HOLD, ST_WRITE_END} smtw_state_t;
endpackage

// [logic/smtw_wait_if.sv]
// external wait pin path between the controller and its synchroniser
`timescale 1ns/10ps
interface smtw_wait_if;
   logic pin;
   logic polarity;
   logic level;
   logic asserted;
   modport sync (input pin, input polarity, output level, output asserted);
   modport ctrl (output pin, output polarity, input level, input asserted);
endinterface

// [logic/smtw_wait_sync.sv]
// two-flop synchroniser for the external wait pin with polarity applied after it
`timescale 1ns/10ps
module smtw_wait_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   smtw_wait_if.sync wif
);
   logic meta_ff;
   logic level_ff;

   // the first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff  <= 1'b0;
         level_ff <= 1'b0;
      end else if (ce) begin
         meta_ff  <= wif.pin;
         level_ff <= meta_ff;
      end
   end

   assign wif.level    = level_ff;
   // polarity after the synchroniser so a polarity change never races the pin
   assign wif.asserted = (wif.polarity == smtw_pkg::POL_HIGH) ? level_ff : ~level_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_sync_two_cycles: assert property ($past(ce, 1) && $past(ce, 2) && !$past(rst, 1) && !$past(rst, 2)
                                       |-> level_ff == $past(wif.pin, 2))
      else $error("wait level is not the pin delayed by two cycles");
endmodule

// [logic/smtw_ctrl.sv]
// static memory turnaround, external wait and byte lane control
// Summary of operation
// - flash writes sequenced exactly like sram writes
// - per-bank turnaround setting up to fifteen
// - turnaround after read before other-bank read or write
// - read then write: write posted, read stalls
// - write then read: read waits for write
// - turnaround starts at first write; second write stalls
// - per-bank wait enable and wait polarity
// - wait pin synchronised, two cycles delay
// - stall while synchronised wait asserted
// - wait disabled: pin ignored, counts only
// - no wait seen before count expiry: zero-wait
// - aborted waited transfer: error and timeout flag
// - wait still asserted: new requests get error
// - wait pin state output shows pin level
// - waited write ends one cycle after read
// - waited writes stall the system side
// - 8 or 16 bit banks, true byte lanes
// - lane assert set: both lanes low on reads
// - size 00 byte, 01 half, 10 word
// - 8-bit reads split, descending lane steering
// - 16-bit reads by halves, lanes both low only with lane assert set
// - turnaround lasts setting plus one cycles
`timescale 1ns/10ps
module smtw_ctrl (
   input  wire logic                                                   clk,
   input  wire logic                                                   rst,
   input  wire logic                                                   ce,
   input  wire logic                                                   req_valid,
   input  wire logic                                                   req_write,
   input  wire logic [smtw_pkg::BANK_W-1:0]                            req_bank,
   input  wire logic [1:0]                                             req_size,
   input  wire logic [1:0]                                             req_addr,
   input  wire logic [31:0]                                            req_wdata,
   input  wire logic                                                   req_abort,
   input  wire logic [smtw_pkg::BANKS-1:0][smtw_pkg::TURN_W-1:0]       turnaround_cycles,
   input  wire logic [smtw_pkg::BANKS-1:0][smtw_pkg::WS_W-1:0]         read_wait_states,
   input  wire logic [smtw_pkg::BANKS-1:0][smtw_pkg::WS_W-1:0]         write_wait_states,
   input  wire logic [smtw_pkg::BANKS-1:0]                             ext_wait_enable,
   input  wire logic [smtw_pkg::BANKS-1:0]                             ext_wait_polarity,
   input  wire logic [smtw_pkg::BANKS-1:0]                             read_byte_lane_assert,
   input  wire logic [smtw_pkg::BANKS-1:0]                             bank_wide,
   input  wire logic [smtw_pkg::BANKS-1:0]                             timeout_clear,
   input  wire logic                                                   ext_wait_in,
   input  wire logic [15:0]                                            ext_rdata,
   output logic                                                        done,
   output logic                                                        resp_error,
   output logic [31:0]                                                 rdata,
   output logic [smtw_pkg::BANKS-1:0]                                  cs_n,
   output logic                                                        we_n,
   output logic                                                        oe_n,
   output logic [1:0]                                                  ext_addr,
   output logic                                                        byte_lane0_n,
   output logic                                                        byte_lane1_n,
   output logic [15:0]                                                 ext_wdata,
   output logic                                                        ext_data_oe_n,
   output logic [smtw_pkg::BANKS-1:0]                                  wait_timeout_error,
   output logic                                                        wait_pin_state
);
   smtw_pkg::smtw_state_t state_ff, nxt_state;
   logic [4:0]  cnt_ff, nxt_cnt;
   logic [1:0]  beat_addr_ff, nxt_beat_addr;
   logic [1:0]  beats_left_ff, nxt_beats_left;
   logic [2:0]  cur_bank_ff, nxt_cur_bank, last_bank_ff, nxt_last_bank;
   logic        cur_write_ff, nxt_cur_write, cur_wide_ff, nxt_cur_wide, cur_addr0_ff, nxt_cur_addr0;
   logic [1:0]  cur_size_ff, nxt_cur_size;
   logic        posted_ff, nxt_posted, last_read_ff, nxt_last_read;
   logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
   logic        done_ff, nxt_done, err_ff, nxt_err;
   logic [7:0]  cs_n_ff, nxt_cs_n, timeout_ff, nxt_timeout, timeout_set;
   logic        we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n, data_oe_n_ff, nxt_data_oe_n;
   logic [1:0]  ext_addr_ff, nxt_ext_addr, lanes_n_ff, nxt_lanes_n;
   logic [15:0] ext_wdata_ff, nxt_ext_wdata;
   logic        launch, beat_done, finish;
   logic [1:0]  l_addr;
   logic [4:0]  turn_len_ff;

   smtw_wait_if wif ();
   smtw_wait_sync u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .wif (wif.sync)
   );
   assign wif.pin      = ext_wait_in;
   assign wif.polarity = ext_wait_polarity[cur_bank_ff];

   // decoding of the incoming request
   wire        in_idle   = (state_ff == smtw_pkg::ST_IDLE);
   wire        take      = ce & req_valid & ~done_ff & in_idle;
   wire        req_wide  = bank_wide[req_bank];
   wire        busy_wait = wif.asserted & ext_wait_enable[cur_bank_ff];
   wire        wait_hit  = wif.asserted & ext_wait_enable[cur_bank_ff];
   wire [3:0]  turnaround_cycles_last = turnaround_cycles[last_bank_ff];
   // a write after a read always turns the bus; a read only when the bank changes
   wire        need_turn = last_read_ff & (req_write | (req_bank != last_bank_ff));
   wire [1:0]  req_beats = req_wide ? ((req_size == smtw_pkg::SIZE_WORD) ? smtw_pkg::BEATS16_WORD
                                                                        : smtw_pkg::BEATS_ONE)
                         : ((req_size == smtw_pkg::SIZE_WORD) ? smtw_pkg::BEATS8_WORD
                         : (req_size == smtw_pkg::SIZE_HALF) ? smtw_pkg::BEATS8_HALF
                                                             : smtw_pkg::BEATS_ONE);
   wire [1:0]  start8    = (req_size == smtw_pkg::SIZE_WORD) ? smtw_pkg::ADDR_WORD8
                         : (req_size == smtw_pkg::SIZE_HALF) ? {req_addr[1], 1'b1} : req_addr;
   wire [1:0]  start16   = (req_size == smtw_pkg::SIZE_WORD) ? smtw_pkg::ADDR_WORD16
                                                             : {req_addr[1], 1'b0};
   wire [1:0]  req_start = req_wide ? start16 : start8;

   // beat launch fields come from the request in idle, else from the latched copy
   wire [2:0]  l_bank  = in_idle ? req_bank : cur_bank_ff;
   wire        l_write = in_idle ? req_write : cur_write_ff;
   wire        l_wide  = in_idle ? req_wide : cur_wide_ff;
   wire        l_addr0 = in_idle ? req_addr[0] : cur_addr0_ff;
   wire [1:0]  l_size  = in_idle ? req_size : cur_size_ff;
   wire [31:0] l_wdata = in_idle ? req_wdata : wdata_ff;
   wire [1:0]  wr_lanes = ~l_wide ? smtw_pkg::LANES_LOW
                        : (l_size != smtw_pkg::SIZE_BYTE) ? smtw_pkg::LANES_BOTH
                        : l_addr0 ? smtw_pkg::LANES_HIGH : smtw_pkg::LANES_LOW;
   // 8-bit banks keep lane assert clear, so their reads leave both lanes high
   wire [1:0]  rd_lanes = read_byte_lane_assert[l_bank] ? smtw_pkg::LANES_BOTH
                                                        : smtw_pkg::LANES_NONE;
   wire [15:0] wr_ext   = l_wide ? (l_addr[1] ? l_wdata[31:16] : l_wdata[15:0])
                                 : {8'h00, l_wdata[{l_addr, 3'h0} +: 8]};
   wire [1:0]  step_addr = beat_addr_ff - (cur_wide_ff ? smtw_pkg::ADDR_STEP16 : smtw_pkg::ADDR_STEP8);
   wire        more_beats = (beats_left_ff != smtw_pkg::BEATS_ONE);

   always_comb begin
      nxt_state = state_ff;         nxt_cnt = cnt_ff;             nxt_beat_addr = beat_addr_ff;
      nxt_beats_left = beats_left_ff; nxt_cur_bank = cur_bank_ff; nxt_last_bank = last_bank_ff;
      nxt_cur_write = cur_write_ff; nxt_cur_wide = cur_wide_ff;   nxt_cur_addr0 = cur_addr0_ff;
      nxt_cur_size = cur_size_ff;   nxt_posted = posted_ff;       nxt_last_read = last_read_ff;
      nxt_wdata = wdata_ff;         nxt_rdata = rdata_ff;         nxt_done = 1'b0;
      nxt_err = 1'b0;               nxt_cs_n = cs_n_ff;           nxt_we_n = we_n_ff;
      nxt_oe_n = oe_n_ff;           nxt_data_oe_n = data_oe_n_ff; nxt_ext_addr = ext_addr_ff;
      nxt_lanes_n = lanes_n_ff;     nxt_ext_wdata = ext_wdata_ff; timeout_set = smtw_pkg::FLAGS_RST;
      launch = 1'b0;                beat_done = 1'b0;             finish = 1'b0;
      l_addr = beat_addr_ff;
      case (state_ff)
         smtw_pkg::ST_IDLE: begin
            if (take && busy_wait) begin
               nxt_done = 1'b1;
               nxt_err  = 1'b1;
            end else if (take) begin
               nxt_cur_bank   = req_bank;
               nxt_cur_write  = req_write;
               nxt_cur_wide   = req_wide;
               nxt_cur_addr0  = req_addr[0];
               nxt_cur_size   = req_size;
               nxt_wdata      = req_wdata;
               nxt_rdata      = smtw_pkg::DATA_RST;
               nxt_beats_left = req_beats;
               nxt_beat_addr  = req_start;
               l_addr         = req_start;
               // plain writes are acknowledged at once; waited writes stall the system side
               nxt_posted = req_write & ~ext_wait_enable[req_bank];
               nxt_done   = req_write & ~ext_wait_enable[req_bank];
               if (need_turn) begin
                  nxt_state = smtw_pkg::ST_TURN;
                  nxt_cnt   = {1'b0, turnaround_cycles_last};
               end else begin
                  launch = 1'b1;
               end
            end
         end
         smtw_pkg::ST_TURN: begin
            if (cnt_ff == smtw_pkg::CNT_ZERO) begin
               launch = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - smtw_pkg::CNT_ONE;
            end
         end
         smtw_pkg::ST_ACCESS: begin
            if (wait_hit) begin
               nxt_state = smtw_pkg::ST_WAIT_HOLD;
            end else if (cnt_ff == smtw_pkg::CNT_ZERO) begin
               beat_done = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - smtw_pkg::CNT_ONE;
            end
         end
         smtw_pkg::ST_WAIT_HOLD: begin
            if (req_abort) begin
               finish      = 1'b1;
               nxt_err     = 1'b1;
               nxt_done    = 1'b1;
               timeout_set = smtw_pkg::CS_ONE << cur_bank_ff;
            end else if (!wif.asserted) begin
               beat_done = 1'b1;
            end
         end
         smtw_pkg::ST_WRITE_END: begin
            if (more_beats) begin
               launch = 1'b1;
               l_addr = step_addr;
            end else begin
               finish = 1'b1;
            end
         end
         default: begin
            nxt_state = smtw_pkg::ST_IDLE;
         end
      endcase
      if (beat_done && cur_write_ff) begin
         // write enable rises a cycle ahead of chip select
         nxt_state = smtw_pkg::ST_WRITE_END;
         nxt_we_n  = 1'b1;
      end else if (beat_done) begin
         if (cur_wide_ff && ext_addr_ff[1]) begin
            nxt_rdata[31:16] = ext_rdata;
         end else if (cur_wide_ff) begin
            nxt_rdata[15:0] = ext_rdata;
         end else begin
            nxt_rdata[{ext_addr_ff, 3'h0} +: 8] = ext_rdata[7:0];
         end
         if (more_beats) begin
            launch = 1'b1;
            l_addr = step_addr;
         end else begin
            finish = 1'b1;
         end
      end
      if (launch) begin
         nxt_state     = smtw_pkg::ST_ACCESS;
         nxt_cs_n      = ~(smtw_pkg::CS_ONE << l_bank);
         nxt_oe_n      = l_write;
         nxt_we_n      = ~l_write;
         nxt_data_oe_n = ~l_write;
         nxt_ext_addr  = l_addr;
         nxt_beat_addr = l_addr;
         nxt_lanes_n   = l_write ? wr_lanes : rd_lanes;
         nxt_ext_wdata = wr_ext;
         nxt_cnt       = l_write ? write_wait_states[l_bank] : read_wait_states[l_bank];
         if (!in_idle && state_ff != smtw_pkg::ST_TURN) begin
            nxt_beats_left = beats_left_ff - smtw_pkg::BEAT_ONE;
         end
      end
      if (finish) begin
         nxt_state     = smtw_pkg::ST_IDLE;
         nxt_cs_n      = smtw_pkg::CS_NONE;
         nxt_oe_n      = 1'b1;
         nxt_we_n      = 1'b1;
         nxt_data_oe_n = 1'b1;
         nxt_lanes_n   = smtw_pkg::LANES_NONE;
         nxt_last_read = ~cur_write_ff;
         nxt_last_bank = cur_bank_ff;
         nxt_done      = nxt_done | ~posted_ff;
      end
      // a timeout that lands in the clearing cycle survives
      nxt_timeout = (timeout_ff & ~timeout_clear) | timeout_set;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= smtw_pkg::ST_IDLE;  cnt_ff <= smtw_pkg::CNT_ZERO;   beat_addr_ff <= smtw_pkg::ADDR_RST;
         beats_left_ff <= smtw_pkg::BEATS_ONE; cur_bank_ff <= smtw_pkg::BANK_RST;
         last_bank_ff <= smtw_pkg::BANK_RST; cur_write_ff <= 1'b0; cur_wide_ff <= 1'b0; cur_addr0_ff <= 1'b0;
         cur_size_ff <= smtw_pkg::SIZE_BYTE; posted_ff <= 1'b0; last_read_ff <= 1'b0;
         wdata_ff <= smtw_pkg::DATA_RST; rdata_ff <= smtw_pkg::DATA_RST; done_ff <= 1'b0; err_ff <= 1'b0;
         cs_n_ff <= smtw_pkg::CS_NONE; we_n_ff <= 1'b1; oe_n_ff <= 1'b1; data_oe_n_ff <= 1'b1;
         ext_addr_ff <= smtw_pkg::ADDR_RST; lanes_n_ff <= smtw_pkg::LANES_NONE;
         ext_wdata_ff <= smtw_pkg::EXT_RST; timeout_ff <= smtw_pkg::FLAGS_RST;
      end else if (ce) begin
         state_ff <= nxt_state;          cnt_ff <= nxt_cnt;              beat_addr_ff <= nxt_beat_addr;
         beats_left_ff <= nxt_beats_left; cur_bank_ff <= nxt_cur_bank;   last_bank_ff <= nxt_last_bank;
         cur_write_ff <= nxt_cur_write;  cur_wide_ff <= nxt_cur_wide;    cur_addr0_ff <= nxt_cur_addr0;
         cur_size_ff <= nxt_cur_size;    posted_ff <= nxt_posted;        last_read_ff <= nxt_last_read;
         wdata_ff <= nxt_wdata;          rdata_ff <= nxt_rdata;          done_ff <= nxt_done;
         err_ff <= nxt_err;              cs_n_ff <= nxt_cs_n;            we_n_ff <= nxt_we_n;
         oe_n_ff <= nxt_oe_n;            data_oe_n_ff <= nxt_data_oe_n;  ext_addr_ff <= nxt_ext_addr;
         lanes_n_ff <= nxt_lanes_n;      ext_wdata_ff <= nxt_ext_wdata;  timeout_ff <= nxt_timeout;
      end
   end

   assign done               = done_ff;
   assign resp_error         = err_ff;
   assign rdata              = rdata_ff;
   assign cs_n               = cs_n_ff;
   assign we_n               = we_n_ff;
   assign oe_n               = oe_n_ff;
   assign ext_addr           = ext_addr_ff;
   assign byte_lane0_n       = lanes_n_ff[0];
   assign byte_lane1_n       = lanes_n_ff[1];
   assign ext_wdata          = ext_wdata_ff;
   assign ext_data_oe_n      = data_oe_n_ff;
   assign wait_timeout_error = timeout_ff;
   assign wait_pin_state     = wif.level;

   // cycles spent in turnaround, read only by the checks below
   always_ff @(posedge clk) begin
      if (rst || state_ff != smtw_pkg::ST_TURN) begin
         turn_len_ff <= smtw_pkg::CNT_ZERO;
      end else if (ce) begin
         turn_len_ff <= turn_len_ff + smtw_pkg::CNT_ONE;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_abort_wait;
      state_ff == smtw_pkg::ST_WAIT_HOLD && req_abort && ce;
   endsequence

   a_turn_length: assert property (state_ff == smtw_pkg::ST_TURN && cnt_ff == smtw_pkg::CNT_ZERO && ce
                                   |-> turn_len_ff == {1'b0, turnaround_cycles_last})
      else $error("turnaround did not last setting plus one cycles");
   a_turn_inserted: assert property (take && !busy_wait && need_turn |=> state_ff == smtw_pkg::ST_TURN && cs_n_ff
                                     == smtw_pkg::CS_NONE)
      else $error("turnaround missing after read");
   a_busy_error: assert property (take && busy_wait |=> done_ff && err_ff && state_ff == smtw_pkg::ST_IDLE)
      else $error("request during held wait was not refused");
   a_abort_flag: assert property (s_abort_wait |=> err_ff && done_ff && timeout_ff[cur_bank_ff]
                                  && cs_n_ff == smtw_pkg::CS_NONE)
      else $error("aborted wait gave no error and flag");
   a_read_lanes: assert property (!oe_n_ff && read_byte_lane_assert[cur_bank_ff]
                                  |-> lanes_n_ff == smtw_pkg::LANES_BOTH)
      else $error("byte lanes not both low on read");
   a_write_end: assert property (state_ff == smtw_pkg::ST_WRITE_END |-> we_n_ff && cs_n_ff != smtw_pkg::CS_NONE)
      else $error("write end cycle without chip select held");
   a_wait_ignored: assert property (state_ff == smtw_pkg::ST_ACCESS && !ext_wait_enable[cur_bank_ff] && ce
                                    |=> state_ff != smtw_pkg::ST_WAIT_HOLD)
      else $error("disabled wait pin stalled a transfer");
   a_waited_write: assert property (take && !busy_wait && req_write && ext_wait_enable[req_bank]
                                    |=> !done_ff ##1 !done_ff)
      else $error("waited write was acknowledged early");
   a_wait_stall: assert property (state_ff == smtw_pkg::ST_WAIT_HOLD && wif.asserted && !req_abort && ce
                                  |=> state_ff == smtw_pkg::ST_WAIT_HOLD && !done_ff)
      else $error("transfer ended while wait asserted");
endmodule

// [bench/smtw_mem_model.sv]
// external memory model: reads return a pattern coded from the address
`timescale 1ns/10ps
module smtw_mem_model (
   input  wire logic        clk,
   input  wire logic [7:0]  cs_n,
   input  wire logic        oe_n,
   input  wire logic [1:0]  ext_addr,
   output logic      [15:0] ext_rdata
);
   logic [15:0] held_ff = 16'h0000;
   wire         rd_act  = (cs_n != 8'hff) && !oe_n;
   wire  [15:0] val     = {4'h2, 2'h0, ext_addr, 4'h1, 2'h0, ext_addr};
   // released bus shows the inverse, so a late sample cannot pass by luck
   assign ext_rdata = rd_act ? val : ~held_ff;
   always @(posedge clk) if (rd_act) held_ff <= val;
endmodule

// [bench/smtw_ctrl_tb.sv]
// self-checking bench for turnaround, external wait and byte lane control
`timescale 1ns/10ps
module smtw_ctrl_tb;
   logic        clk = 0, rst = 1, req_valid = 0, req_write = 0, req_abort = 0, pin = 0, ce = 1;
   logic [2:0]  req_bank = 3'h0;
   logic [1:0]  req_size = 2'h0, req_addr = 2'h0, ext_addr;
   logic [31:0] req_wdata = 32'h0, rd, rdata;
   // lane assert stays clear on the 8-bit banks
   logic [7:0]  tclr = 8'h00, cs_n, flag, wen = 8'h04, pol = 8'h05, rbl = 8'h02, bw = 8'h02;
   logic [31:0] tc = {8{4'h2}};
   logic [39:0] rws = 40'h00_0000_0c00, wws = 40'h0;
   logic [15:0] ext_rdata, ext_wdata;
   logic        done, resp_error, e, we_n, oe_n, bl0, bl1, wps;
   int          err_count = 0, checks_done = 0, n, n0;
   always #2 clk = ~clk;
   smtw_ctrl uut (.clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req_write(req_write),
      .req_bank(req_bank), .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_abort(req_abort), .turnaround_cycles(tc), .read_wait_states(rws),
      .write_wait_states(wws), .ext_wait_enable(wen), .ext_wait_polarity(pol),
      .read_byte_lane_assert(rbl), .bank_wide(bw), .timeout_clear(tclr), .ext_wait_in(pin),
      .ext_rdata(ext_rdata), .done(done), .resp_error(resp_error), .rdata(rdata), .cs_n(cs_n),
      .we_n(we_n), .oe_n(oe_n), .ext_addr(ext_addr), .byte_lane0_n(bl0), .byte_lane1_n(bl1),
      .ext_wdata(ext_wdata), .ext_data_oe_n(), .wait_timeout_error(flag), .wait_pin_state(wps));
   smtw_mem_model mem (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .ext_addr(ext_addr), .ext_rdata(ext_rdata));
   task automatic chk(input bit ok, input string m);
      checks_done++;
      if (!ok) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // raises the request one falling edge in, so valid never drops and rises in one step;
   // n counts rising edges from the raise to done
   task automatic xfer(input logic w, input logic [2:0] b, input logic [1:0] s, a, input logic [31:0] wd);
      n = 0;
      @(negedge clk);
      {req_write, req_bank, req_size, req_addr, req_wdata, req_valid} = {w, b, s, a, wd, 1'b1};
      do begin
         @(posedge clk);
         #1 n++;
      end while (done !== 1'b1 && n < 200);
      if (n >= 200) begin
         chk(0, "no done");
         tally_and_finish;
      end else begin
         e = resp_error;
         rd = rdata;
         @(negedge clk);
         req_valid = 0;
      end
   endtask
   always @(negedge clk) if (!rst && cs_n[1] === 1'b0 && oe_n === 1'b0) chk({bl1, bl0} === 2'b00, "lanes");
   initial begin
      repeat (10) @(negedge clk);
      rst = 0;
      xfer(0, 0, 0, 1, 0); chk(rd === 32'h0000_1100 && e === 1'b0, "byte");
      n0 = n;
      xfer(0, 1, 0, 0, 0); chk(n - n0 == 3, "turnaround");
      xfer(0, 1, 2, 0, 0); chk(rd === 32'h2212_2010, "16b word");
      xfer(0, 0, 2, 0, 0); chk(rd === 32'h1312_1110, "8b word");
      xfer(0, 0, 1, 2, 0); chk(rd === 32'h1312_0000, "8b half");
      pin = 1;
      repeat (3) @(negedge clk);
      xfer(0, 0, 0, 0, 0); chk(e === 1'b0 && n == n0 && wps === 1'b1, "wait off");
      xfer(1, 0, 0, 2, 32'h00ab_0000); chk(n == 1 && e === 1'b0, "posted write");
      // the write beat follows the three turnaround cycles
      repeat (3) @(negedge clk);
      chk(we_n === 1'b0 && cs_n === 8'hfe && bl0 === 1'b0 && ext_wdata[7:0] === 8'hab, "write beat");
      fork
         xfer(0, 2, 0, 0, 0);
         begin
            repeat (10) @(negedge clk);
            req_abort = 1;
         end
      join
      req_abort = 0;
      chk(e === 1'b1 && flag[2] === 1'b1 && n > 9, "abort");
      xfer(0, 2, 0, 0, 0); chk(e === 1'b1 && n == 1, "refuse");
      pin = 0;
      repeat (4) @(negedge clk);
      chk(wps === 1'b0, "pin state");
      xfer(0, 2, 0, 0, 0); chk(e === 1'b0 && rd === 32'h0000_0010 && n == n0 + 3, "resume");
      // wait raised during the count, released six cycles later, seen two cycles late
      fork
         xfer(0, 2, 0, 0, 0);
         begin
            repeat (3) @(negedge clk);
            pin = 1;
            repeat (6) @(negedge clk);
            pin = 0;
         end
      join
      chk(e === 1'b0 && rd === 32'h0000_0010 && n == 11, "waited read");
      xfer(1, 2, 0, 0, 32'h0000_0055); chk(e === 1'b0 && n == n0 + 4, "waited write");
      ce = 0;
      tclr = 8'h04;
      @(negedge clk);
      tclr = 8'h00;
      chk(flag[2] === 1'b1, "clear while frozen");
      ce = 1;
      tclr = 8'h04;
      @(negedge clk);
      tclr = 8'h00;
      @(negedge clk);
      chk(flag === 8'h00, "flag clear");
      tally_and_finish;
   end
endmodule
